// File: fis_flash_core.sv
// self-timed flash storage: option byte, security block, upper bank
`timescale 1ns/10ps
`include "fis_map.svh"
module fis_flash_core
  import fis_pkg::*;
(
  input wire logic core_clk,  // system clock
  input wire logic rstSync_n, // synchronised reset, active low
  fis_flash_if.core fl        // sequencer side
);
  fis_core_s s;
  fis_core_s next_s;

  // final timer count of each operation kind: its duration in clock cycles less one
  function automatic logic [11:0] opCycles(input fis_op_e k);
    if (k == OP_ERASE_OPT || k == OP_ERASE_SEC || k == OP_ERASE_BANK)
      opCycles = 12'(`FIS_ERASE_CYCLES - 1);
    else
      opCycles = 12'(`FIS_PROG_CYCLES - 1);
  endfunction

  // flash can only clear bits; asking for a one over a zero fails
  function automatic logic progFails(input logic [7:0] old,
                                     input logic [7:0] val);
    progFails = |(val & ~old);
  endfunction

  // combinational read port, sequencer latches it a cycle later
  always_comb begin
    case (fl.rdSpace)
      SP_OPT:  fl.rdData = s.opt;
      SP_SEC:  fl.rdData = (fl.rdAddr[7:0] > `FIS_SEC_LOCK) ? `FIS_ERASED :
                           s.sec[fl.rdAddr[6:0]];
      SP_BANK: fl.rdData = s.bank[fl.rdAddr[12:0]];
      default: fl.rdData = `FIS_ERASED;
    endcase
  end
  assign fl.optByte = s.opt;
  assign fl.opDone  = s.done;
  assign fl.opFail  = s.fail;

  // operation timer and array update at the end of the timed window
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.fail = 1'b0;
    case (s.cstate)
      CS_READY: begin
        if (fl.opStart) begin
          next_s.kind   = fl.opKind;
          next_s.addr   = fl.opAddr;
          next_s.data   = fl.opData;
          next_s.timer  = 12'h000;
          next_s.cstate = CS_TIMING;
        end
      end
      CS_TIMING: begin
        next_s.timer = s.timer + 12'h001;
        if (s.timer == opCycles(s.kind)) begin
          next_s.done   = 1'b1;
          next_s.cstate = CS_READY;
          case (s.kind)
            OP_PROG_OPT: begin
              next_s.fail = progFails(s.opt, s.data);
              next_s.opt  = s.opt & s.data;
            end
            OP_PROG_SEC: begin
              next_s.fail = progFails(s.sec[s.addr[6:0]], s.data);
              next_s.sec[s.addr[6:0]] = s.sec[s.addr[6:0]] & s.data;
            end
            OP_PROG_BANK: begin
              next_s.fail = progFails(s.bank[s.addr[12:0]], s.data);
              next_s.bank[s.addr[12:0]] = s.bank[s.addr[12:0]] & s.data;
            end
            OP_ERASE_OPT:  next_s.opt = `FIS_ERASED;
            OP_ERASE_SEC:  next_s.sec = '1;
            OP_ERASE_BANK: next_s.bank = '1;
            default:       next_s.fail = 1'b1;
          endcase
        end
      end
      default: next_s.cstate = CS_READY;
    endcase
  end

  // flops hold no charge across reset, so they come up erased
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      s <= '1;
      s.cstate <= CS_READY;
      s.kind <= OP_PROG_OPT;
      s.addr <= 16'h0000;
      s.data <= 8'h00;
      s.timer <= 12'h000;
      s.done <= 1'b0;
      s.fail <= 1'b0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// File: fis_flash_if.sv
// link between the sequencer and the flash core
`timescale 1ns/10ps
interface fis_flash_if;
  import fis_pkg::*;
  logic        opStart;
  fis_op_e     opKind;
  logic [15:0] opAddr;
  logic [7:0]  opData;
  logic        opDone;
  logic        opFail;
  fis_space_e  rdSpace;
  logic [15:0] rdAddr;
  logic [7:0]  rdData;
  logic [7:0]  optByte;
  modport seq  (output opStart, opKind, opAddr, opData, rdSpace, rdAddr,
                input  opDone, opFail, rdData, optByte);
  modport core (input  opStart, opKind, opAddr, opData, rdSpace, rdAddr,
                output opDone, opFail, rdData, optByte);
endinterface

// File: fis_map.svh
// constants of the in-application flash sequencer: offsets, codes, timing
// Operation
// - verify-bank: two address bytes written, byte returned next cycle
// - write-option command programs option byte; bit 3 is watchdog default
// - write-security: first write location, second data; locks at 40h
// - write-bank: address high, address low, then code byte programmed
// - erase-option returns option byte to ffh, watchdog off at power-up
// - erase-security sets whole security block, locks included, to ffh
// - erase-bank sets every upper bank location to ffh
// - system-reset command code makes the device request full reset
// - every reset clears command field to read mode, no operation
// - in read mode idle and error flags carry no meaning
// - control register writes accepted only under timed access
// - commands written while an operation runs are ignored
// - reset high with both strobe pins low selects loader mode
// - idle flag bit 7 resets to one, low while operation runs
// - failed operation terminates and sets error flag bit 6
// - operation starts once its last byte reaches the data register
// - command field is bits 3 to 0 of control register
`ifndef FIS_MAP_SVH
`define FIS_MAP_SVH
`define FIS_CTRL_ADDR     8'hd5
`define FIS_DATA_ADDR     8'hd6
`define FIS_IDLE_BIT      7
`define FIS_ERR_BIT       6
`define FIS_CMD_MSB       3
`define FIS_CMD_RESET     4'h0
`define FIS_IDLE_RESET    1'b1
`define FIS_CMD_READ      4'h0
`define FIS_CMD_VER_OPT   4'h1
`define FIS_CMD_VER_SEC   4'h2
`define FIS_CMD_VER_BANK  4'h3
`define FIS_CMD_WR_OPT    4'h9
`define FIS_CMD_WR_SEC    4'ha
`define FIS_CMD_WR_BANK   4'hb
`define FIS_CMD_ER_OPT    4'hc
`define FIS_CMD_ER_SEC    4'hd
`define FIS_CMD_ER_BANK   4'he
`define FIS_CMD_SYS_RST   4'hf
`define FIS_BANK_LO       16'h2000
`define FIS_BANK_HI       16'h3fff
`define FIS_BANK_WORDS    8192
`define FIS_SEC_WORDS     65
`define FIS_SEC_LOCK      8'h40
`define FIS_ERASED        8'hff
`define FIS_WDOG_BIT      3
`define FIS_CLK_MHZ       125
`define FIS_PROG_TIME_US  20
`define FIS_ERASE_TIME_US 30
`define FIS_PROG_CYCLES   (`FIS_PROG_TIME_US * `FIS_CLK_MHZ)
`define FIS_ERASE_CYCLES  (`FIS_ERASE_TIME_US * `FIS_CLK_MHZ)
`endif

// File: fis_pkg.sv
// types shared by the flash sequencer and its flash core
`include "fis_map.svh"
package fis_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_VERIFY = 3'b010,
    ST_BUSY   = 3'b100
  } fis_state_e;
  typedef enum logic [1:0] {
    CS_READY  = 2'b01,
    CS_TIMING = 2'b10
  } fis_core_e;
  typedef enum logic [2:0] {
    OP_PROG_OPT, OP_PROG_SEC, OP_PROG_BANK,
    OP_ERASE_OPT, OP_ERASE_SEC, OP_ERASE_BANK
  } fis_op_e;
  typedef enum logic [1:0] {
    SP_OPT, SP_SEC, SP_BANK
  } fis_space_e;
  typedef struct packed {
    fis_state_e state;
    logic [3:0] cmd;
    logic       idle;
    logic       err;
    logic [7:0] dataReg;
    logic [7:0] addrHi;
    logic [7:0] addrLo;
    logic [1:0] byteCnt;
    logic       served;
    logic [7:0] rdData;
    logic       sysRst;
    logic       loader;
    logic       wdog;
    logic       opStart;
    fis_op_e    opKind;
    logic [7:0] opData;
  } fis_seq_s;
  typedef struct packed {
    fis_core_e                           cstate;
    fis_op_e                             kind;
    logic [15:0]                         addr;
    logic [7:0]                          data;
    logic [11:0]                         timer;
    logic                                done;
    logic                                fail;
    logic [7:0]                          opt;
    logic [`FIS_SEC_WORDS-1:0][7:0]      sec;
    logic [`FIS_BANK_WORDS-1:0][7:0]     bank;
  } fis_core_s;
endpackage

// File: fis_sequencer.sv
// in-application flash command sequencer with its register port
`timescale 1ns/10ps
`include "fis_map.svh"
module fis_sequencer
  import fis_pkg::*;
(
  input  wire logic       core_clk,         // 125 MHz system clock
  input  wire logic       rst_n,            // async reset, active low
  input  wire logic [7:0] regAddr,          // register address
  input  wire logic [7:0] regWdata,         // register write data
  input  wire logic       regWr,            // write strobe
  input  wire logic       regRd,            // read strobe
  input  wire logic       timedAccessOpen,  // timed access window open
  input  wire logic       resetPin,         // reset pin level
  input  wire logic       externalAccessPinN,   // external access, low act
  input  wire logic       programStoreStrobePinN, // store strobe, low act
  output logic      [7:0] regRdata,         // read data, cycle after read
  output logic            sysResetReq,      // one-cycle system reset pulse
  output logic            loaderMode,       // loader rom selected
  output logic            watchdogPorDefault, // option byte watchdog bit
  output logic            flashIdle         // mirror of the idle flag
);
  fis_seq_s   s;
  fis_seq_s   next_s;
  logic [1:0] rstPipe;
  logic       rstSync_n;

  fis_flash_if flash ();

  fis_flash_core u_core (
    .core_clk  (core_clk),
    .rstSync_n (rstSync_n),
    .fl        (flash.core)
  );

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync_n = rstPipe[1];

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // upper bank window check, used by verify and program alike
  function automatic logic bankInRange(input logic [7:0] hi,
                                       input logic [7:0] lo);
    bankInRange = ({hi, lo} >= `FIS_BANK_LO) && ({hi, lo} <= `FIS_BANK_HI);
  endfunction

  // security block holds locations 00h through the lock byte
  function automatic logic secInRange(input logic [7:0] a);
    secInRange = (a <= `FIS_SEC_LOCK);
  endfunction

  // register image of the control register
  function automatic logic [7:0] ctrlImage(input fis_seq_s v);
    logic [7:0] r;
    r = 8'h00;
    r[`FIS_IDLE_BIT] = v.idle;
    r[`FIS_ERR_BIT]  = v.err;
    r[`FIS_CMD_MSB:0] = v.cmd;
    ctrlImage = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // flash link driven from registered state only
  assign flash.opStart = s.opStart;
  assign flash.opKind  = s.opKind;
  assign flash.opAddr  = {s.addrHi, s.addrLo};
  assign flash.opData  = s.opData;
  assign flash.rdAddr  = {s.addrHi, s.addrLo};

  // read space follows the verify command held in the field
  always_comb begin
    case (s.cmd)
      `FIS_CMD_VER_OPT: flash.rdSpace = SP_OPT;
      `FIS_CMD_VER_SEC: flash.rdSpace = SP_SEC;
      default:          flash.rdSpace = SP_BANK;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state flops
  assign regRdata           = s.rdData;
  assign sysResetReq        = s.sysRst;
  assign loaderMode         = s.loader;
  assign watchdogPorDefault = s.wdog;
  assign flashIdle          = s.idle;

  ////////////////////////////////////////////////////////////////////////////
  // next state of the sequencer
  always_comb begin
    logic ctrlWr;
    logic dataWr;
    logic accept;
    logic feed;
    ctrlWr = regWr && (regAddr == `FIS_CTRL_ADDR);
    dataWr = regWr && (regAddr == `FIS_DATA_ADDR);
    accept = 1'b0;
    feed   = 1'b0;
    next_s = s;
    next_s.opStart = 1'b0;
    next_s.sysRst  = 1'b0;

    // pins taken as synchronous; level holds while condition stands
    next_s.loader = resetPin && !externalAccessPinN &&
                    !programStoreStrobePinN;
    next_s.wdog = flash.optByte[`FIS_WDOG_BIT];

    // read port answers one cycle after the strobe and only then
    next_s.rdData = 8'h00;
    if (regRd) begin
      case (regAddr)
        `FIS_CTRL_ADDR: next_s.rdData = ctrlImage(s);
        `FIS_DATA_ADDR: next_s.rdData = s.dataReg;
        default:        next_s.rdData = 8'h00;
      endcase
    end

    // command accepted only through timed access and only when idle
    accept = ctrlWr && timedAccessOpen &&
             s.idle && (s.state == ST_IDLE);
    feed = dataWr && (s.state == ST_IDLE) && !s.served &&
           (s.cmd != `FIS_CMD_READ);

    if (accept) begin
      next_s.cmd     = regWdata[`FIS_CMD_MSB:0];
      next_s.byteCnt = 2'b00;
      next_s.served  = 1'b0;
      next_s.err     = 1'b0;
      case (regWdata[`FIS_CMD_MSB:0])
        `FIS_CMD_SYS_RST: next_s.sysRst = 1'b1;
        `FIS_CMD_VER_OPT: next_s.state = ST_VERIFY;
        default:          next_s.state = ST_IDLE;
      endcase
    end

    // data register stores every write outside the verify cycle; the slot follows the count
    if (dataWr) begin
      next_s.dataReg = regWdata;
    end
    if (feed) begin
      next_s.byteCnt = s.byteCnt + 2'b01;
      case (s.cmd)
        `FIS_CMD_VER_SEC: begin
          next_s.addrHi  = 8'h00;
          next_s.addrLo  = regWdata;
          next_s.byteCnt = 2'b00;
          if (secInRange(regWdata)) begin
            next_s.state = ST_VERIFY;
          end else begin
            next_s.err = 1'b1;
          end
        end
        `FIS_CMD_VER_BANK: begin
          if (s.byteCnt == 2'b00) begin
            next_s.addrHi = regWdata;
          end else begin
            next_s.addrLo  = regWdata;
            next_s.byteCnt = 2'b00;
            if (bankInRange(s.addrHi, regWdata)) begin
              next_s.state = ST_VERIFY;
            end else begin
              next_s.err = 1'b1;
            end
          end
        end
        `FIS_CMD_WR_OPT: begin
          next_s.opKind  = OP_PROG_OPT;
          next_s.opData  = regWdata;
          next_s.opStart = 1'b1;
        end
        `FIS_CMD_WR_SEC: begin
          if (s.byteCnt == 2'b00) begin
            next_s.addrHi = 8'h00;
            next_s.addrLo = regWdata;
          end else if (secInRange(s.addrLo)) begin
            next_s.opKind  = OP_PROG_SEC;
            next_s.opData  = regWdata;
            next_s.opStart = 1'b1;
          end else begin
            next_s.err    = 1'b1;
            next_s.served = 1'b1;
          end
        end
        `FIS_CMD_WR_BANK: begin
          if (s.byteCnt == 2'b00) begin
            next_s.addrHi = regWdata;
          end else if (s.byteCnt == 2'b01) begin
            next_s.addrLo = regWdata;
          end else if (bankInRange(s.addrHi, s.addrLo)) begin
            next_s.opKind  = OP_PROG_BANK;
            next_s.opData  = regWdata;
            next_s.opStart = 1'b1;
          end else begin
            next_s.err    = 1'b1;
            next_s.served = 1'b1;
          end
        end
        // erases carry no payload, any data write triggers them
        `FIS_CMD_ER_OPT: begin
          next_s.opKind  = OP_ERASE_OPT;
          next_s.opStart = 1'b1;
        end
        `FIS_CMD_ER_SEC: begin
          next_s.opKind  = OP_ERASE_SEC;
          next_s.opStart = 1'b1;
        end
        `FIS_CMD_ER_BANK: begin
          next_s.opKind  = OP_ERASE_BANK;
          next_s.opStart = 1'b1;
        end
        // reserved and unknown codes start nothing; their data writes only load the data register
        default: next_s.byteCnt = s.byteCnt;
      endcase
    end

    // an issued operation clears idle and consumes the command
    if (next_s.opStart) begin
      next_s.idle   = 1'b0;
      next_s.served = 1'b1;
      next_s.state  = ST_BUSY;
    end

    case (s.state)
      ST_IDLE: begin
        next_s.state = next_s.state;
      end
      // array word is valid the cycle after the address settles
      ST_VERIFY: begin
        next_s.dataReg = flash.rdData;
        next_s.state   = ST_IDLE;
      end
      ST_BUSY: begin
        if (flash.opDone) begin
          next_s.idle  = 1'b1;
          next_s.err   = flash.opFail;
          next_s.state = ST_IDLE;
        end
      end
      default: next_s.state = ST_IDLE;
    endcase

    // a self-issued reset leaves the field in read mode
    if (s.sysRst) begin
      next_s.cmd     = `FIS_CMD_READ;
      next_s.byteCnt = 2'b00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; any reset returns to read mode and idle
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      s.state   <= ST_IDLE;
      s.cmd     <= `FIS_CMD_RESET;
      s.idle    <= `FIS_IDLE_RESET;
      s.err     <= 1'b0;
      s.dataReg <= 8'h00;
      s.addrHi  <= 8'h00;
      s.addrLo  <= 8'h00;
      s.byteCnt <= 2'b00;
      s.served  <= 1'b0;
      s.rdData  <= 8'h00;
      s.sysRst  <= 1'b0;
      s.loader  <= 1'b0;
      s.wdog    <= 1'b1;
      s.opStart <= 1'b0;
      s.opKind  <= OP_PROG_OPT;
      s.opData  <= 8'h00;
    end else begin
      s <= next_s;
    end
  end
endmodule

// File: fis_sequencer_sva.sv
// concurrent checks on the flash sequencer's ports
`timescale 1ns/10ps
`include "fis_map.svh"
module fis_sequencer_sva (
  input wire logic       core_clk,               // system clock
  input wire logic       rst_n,                  // reset, active low
  input wire logic [7:0] regAddr,                // register address
  input wire logic [7:0] regWdata,               // write data
  input wire logic       regWr,                  // write strobe
  input wire logic       regRd,                  // read strobe
  input wire logic       timedAccessOpen,        // timed access open
  input wire logic       resetPin,               // reset pin level
  input wire logic       externalAccessPinN,     // external access, low
  input wire logic       programStoreStrobePinN, // store strobe, low
  input wire logic [7:0] regRdata,               // read data
  input wire logic       sysResetReq,            // reset pulse
  input wire logic       loaderMode,             // loader selected
  input wire logic       watchdogPorDefault,     // watchdog default bit
  input wire logic       flashIdle               // idle flag
);
  int busyCnt;
  ////////////////////////////////////////////////////////////////////////
  // counts busy cycles; a delay range cannot reach the erase time
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busyCnt <= 0;
    end else begin
      busyCnt <= flashIdle ? 0 : busyCnt + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // assertions, all in the core clock domain
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_rdata_quiet: assert property (!$past(regRd) |->
    regRdata == 8'h00)
    else $error("read data seen outside its cycle");
  chk_idle_start: assert property ($fell(flashIdle) |->
    $past(regWr && regAddr == `FIS_DATA_ADDR) ||
    $past(regWr && regAddr == `FIS_DATA_ADDR, 2))
    else $error("operation started without a data write");
  chk_idle_hold: assert property ($fell(flashIdle) |=>
    !flashIdle [*8])
    else $error("idle returned too soon");
  chk_busy_bound: assert property (busyCnt < 3800)
    else $error("operation ran past its time");
  chk_busy_ignore: assert property (!flashIdle && regWr &&
    regAddr == `FIS_CTRL_ADDR |=> !sysResetReq [*2])
    else $error("command taken while busy");
  chk_sysrst_cause: assert property (sysResetReq |-> $past(regWr &&
    timedAccessOpen && regAddr == `FIS_CTRL_ADDR && regWdata[3:0] == 4'hf))
    else $error("reset pulse without its command");
  chk_sysrst_pulse: assert property (sysResetReq |=> !sysResetReq)
    else $error("reset pulse longer than one cycle");
  chk_loader_track: assert property (loaderMode == $past(resetPin &&
    !externalAccessPinN && !programStoreStrobePinN))
    else $error("loader mode does not follow the pins");
  chk_wdog_after_op: assert property (
    $changed(watchdogPorDefault) |->
    !$past(flashIdle) || !$past(flashIdle, 2))
    else $error("watchdog default changed without an operation");
endmodule
bind fis_sequencer fis_sequencer_sva u_fis_sequencer_sva (
  .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .timedAccessOpen(timedAccessOpen), .resetPin(resetPin),
  .externalAccessPinN(externalAccessPinN),
  .programStoreStrobePinN(programStoreStrobePinN), .regRdata(regRdata),
  .sysResetReq(sysResetReq), .loaderMode(loaderMode),
  .watchdogPorDefault(watchdogPorDefault), .flashIdle(flashIdle));

// File: fis_sequencer_test.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/10ps
`include "fis_map.svh"
module fis_sequencer_test;
  logic        core_clk, rst_n, regWr, regRd, timedAccessOpen;
  logic        resetPin, externalAccessPinN, programStoreStrobePinN;
  logic [7:0]  regAddr, regWdata, regRdata, q, dat;
  logic        sysResetReq, loaderMode, watchdogPorDefault, flashIdle;
  logic [15:0] adr;
  logic [7:0]  bankM [logic [15:0]];
  int          bad_count = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          pulses;
  fis_sequencer u_fis_sequencer (
    .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .timedAccessOpen(timedAccessOpen), .resetPin(resetPin),
    .externalAccessPinN(externalAccessPinN),
    .programStoreStrobePinN(programStoreStrobePinN), .regRdata(regRdata),
    .sysResetReq(sysResetReq), .loaderMode(loaderMode),
    .watchdogPorDefault(watchdogPorDefault), .flashIdle(flashIdle));
  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard; the longest erase is well under this ceiling
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // model lookup: unwritten bank bytes read as erased
  function automatic logic [7:0] memAt(input logic [15:0] a);
    return bankM.exists(a) ? bankM[a] : 8'hff;
  endfunction
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic ta);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    timedAccessOpen <= ta;
    @(posedge core_clk);
    regWr <= 1'b0;
    timedAccessOpen <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask
  task automatic cwr(input logic [3:0] c);
    wr(`FIS_CTRL_ADDR, {4'h0, c}, 1'b1);
  endtask
  task automatic dwr(input logic [7:0] d);
    wr(`FIS_DATA_ADDR, d, 1'b0);
  endtask
  task automatic waitIdle;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (flashIdle !== 1'b1 && n < 5000);
    chk("idle", 8'h01, {7'h0, flashIdle});
  endtask
  // command, n address bytes, then read back the data register
  task automatic vrf(input logic [3:0] c, input logic [15:0] a,
                     input int n, input logic [7:0] e);
    cwr(c);
    if (n == 2) dwr(a[15:8]);
    if (n > 0) dwr(a[7:0]);
    repeat (2) @(posedge core_clk);
    rd(`FIS_DATA_ADDR, q);
    chk("verify", e, q);
  endtask
  // command, n address bytes, data byte, then wait for the end
  task automatic op(input logic [3:0] c, input logic [15:0] a,
                    input int n, input logic [7:0] d);
    cwr(c);
    if (n == 2) dwr(a[15:8]);
    if (n > 0) dwr(a[7:0]);
    dwr(d);
    waitIdle();
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_n = 1'b0;
    {regWr, regRd, timedAccessOpen, resetPin} = 4'h0;
    {externalAccessPinN, programStoreStrobePinN} = 2'h3;
    {regAddr, regWdata} = 16'h0000;
    void'($urandom(63409));
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(`FIS_CTRL_ADDR, q);
    chk("ctrl", 8'h80, q);
    chk("wdog", 8'h01, {7'h0, watchdogPorDefault});
    wr(`FIS_CTRL_ADDR, 8'h0b, 1'b0);
    rd(`FIS_CTRL_ADDR, q);
    chk("ctrl", 8'h80, q);
    rd(8'h00, q);
    chk("unmapped", 8'h00, q);
    $display("test reset done");
    adr = 16'h2000 + 16'($urandom % 8192);
    dat = 8'($urandom);
    cwr(4'hb);
    dwr(adr[15:8]);
    dwr(adr[7:0]);
    dwr(dat);
    @(posedge core_clk);
    #1 chk("idle", 8'h00, {7'h0, flashIdle});
    cwr(4'hf);
    rd(`FIS_CTRL_ADDR, q);
    chk("ctrl", 8'h0b, q);
    waitIdle();
    bankM[adr] = dat;
    dwr(adr[15:8]);
    dwr(adr[7:0] ^ 8'h01);
    dwr(8'h00);
    @(posedge core_clk);
    #1 chk("idle", 8'h01, {7'h0, flashIdle});
    vrf(4'h3, adr, 2, memAt(adr));
    vrf(4'h3, adr ^ 16'h0001, 2, memAt(adr ^ 16'h0001));
    $display("test bank write done");
    cwr(4'hb);
    dwr(8'h10);
    dwr(8'h00);
    dwr(8'h55);
    repeat (2) @(posedge core_clk);
    rd(`FIS_CTRL_ADDR, q);
    chk("ctrl", 8'hcb, q);
    cwr(4'h0);
    rd(`FIS_CTRL_ADDR, q);
    chk("ctrl", 8'h80, q);
    $display("test bad address done");
    op(4'h9, 16'h0000, 0, 8'hf7);
    vrf(4'h1, 16'h0000, 0, 8'hf7);
    chk("wdog", 8'h00, {7'h0, watchdogPorDefault});
    // a one over a programmed zero cannot be written: the op fails
    op(4'h9, 16'h0000, 0, 8'h08);
    rd(`FIS_CTRL_ADDR, q);
    chk("ctrl", 8'hc9, q);
    op(4'hc, 16'h0000, 0, 8'h00);
    vrf(4'h1, 16'h0000, 0, 8'hff);
    chk("wdog", 8'h01, {7'h0, watchdogPorDefault});
    op(4'ha, 16'h0040, 1, 8'hc7);
    vrf(4'h2, 16'h0040, 1, 8'hc7);
    op(4'hd, 16'h0000, 0, 8'h00);
    vrf(4'h2, 16'h0040, 1, 8'hff);
    op(4'he, 16'h0000, 0, 8'h00);
    bankM.delete();
    vrf(4'h3, adr, 2, memAt(adr));
    $display("test option security erase done");
    // reset in the middle of an erase, then the erase is issued again
    cwr(4'he);
    dwr(8'h00);
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b0;
    @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(`FIS_CTRL_ADDR, q);
    chk("ctrl", 8'h80, q);
    op(4'he, 16'h0000, 0, 8'h00);
    $display("test reset mid erase done");
    cwr(4'hf);
    pulses = 0;
    repeat (4) begin
      #1 pulses += int'(sysResetReq === 1'b1);
      @(posedge core_clk);
    end
    chk("pulses", 8'h01, 8'(pulses));
    rd(`FIS_CTRL_ADDR, q);
    chk("ctrl", 8'h80, q);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      {resetPin, externalAccessPinN, programStoreStrobePinN} <= 3'(i);
      repeat (2) @(posedge core_clk);
      #1 chk("loader", {7'h0, i == 4}, {7'h0, loaderMode});
    end
    $display("test reset and loader done");
    tally_and_finish();
  end
endmodule
